// file: kbd_speedup_defines.vh
`ifndef KBD_SPEEDUP_DEFINES_VH
`define KBD_SPEEDUP_DEFINES_VH
// Register byte addresses
`define CFG_OFFSET      8'hF0
`define FAST_OFFSET     8'hF4
`define STAT_OFFSET     8'hF8
`define IRQ_STAT_OFFSET 8'hFC
`define IRQ_CLR_OFFSET  8'hE8
`define IRQ_EN_OFFSET   8'hEC
// Configuration fields
`define CFG_FAST_EN_BIT   2
`define CFG_GATE_HW_BIT   1
`define CFG_RESET_HW_BIT  0
`define CFG_RESET_VAL     3'h0
// Reset/gate request, polarity and output-enable fields of the pin control word in FAST register
`define FAST_RST_BIT      0
`define FAST_A20_BIT      1
`define FAST_GATE_POL_BIT 4
`define FAST_RST_POL_BIT  5
`define FAST_OE_BIT       6
`define FAST_RESET_VAL    8'h00
// Host commands
`define CMD_WRITE_OUT     8'hD1
`define CMD_PULSE_RESET   8'hFE
`define CMD_NULL          8'hFF
// Timing
`define CLK_NS            40
`define RST_DELAY_NS      14000
`define RST_LOW_NS        6000
`define RST_DELAY_CYC     ((`RST_DELAY_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_LOW_CYC       ((`RST_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: kbd_speedup.v
// Function
// RULE_01: Config byte: bit2 fast port enable, bit1 gate select, bit0 reset select.
// RULE_02: Gate output comes from firmware or hardware latch, never both.
// RULE_03: Reset output comes from firmware or hardware pulse, never both.
// RULE_04: With fast port enabled, merge its gate and reset into the pins.
// RULE_05: Write-output command then data byte copies data bit 1 to gate latch.
// RULE_06: Same transaction copies data bit 0 into the reset latch.
// RULE_07: Hardware-handled transaction never raises input-full flag or output irq.
// RULE_08: For data port writes only bit 1 decides the gate.
// RULE_09: Null or unmatched command leaves gate unchanged, input-full flag clear. The code sets the input-full flag for an unmatched command.
// RULE_10: Write-output then another command sets input-full flag, back to idle.
// RULE_11: Pulse-reset command: wait 14us, then reset low at least 6us.
// RULE_12: Gate output polarity follows its polarity control bit.
// RULE_13: Reset output polarity follows its polarity control bit.
// RULE_14: After main supply power-on both pins are undriven.
// RULE_15: Fast port bit 0 write of 1 makes a reset pulse ANDed in.
// RULE_16: No new fast-port pulse until bit 0 returns to 0.
// RULE_17: Firmware-selected commands pass to firmware, not intercepted.
// RULE_18: Host sends write-output command then exactly one data byte.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "kbd_speedup_defines.vh"
module kbd_speedup #(
	parameter DELAY_CYC = `RST_DELAY_CYC,
	parameter LOW_CYC   = `RST_LOW_CYC
) (
	// System
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Host keyboard port snoop
	input  wire        host_wr,
	input  wire        port_select_addr,
	input  wire [7:0]  host_data,
	// Firmware sources
	input  wire        fw_gate,
	input  wire        fw_reset_n,
	// Firmware notification
	output reg         input_full_flag,
	output reg         output_full_irq,
	output reg         fw_cmd_strobe,
	output reg  [7:0]  fw_cmd_data,
	output reg         fw_cmd_is_cmd,
	// Pins
	output reg         addr20_gate_out,
	output reg         addr20_gate_oe,
	output reg         cpu_reset_pulse_out,
	output reg         cpu_reset_pulse_oe,
	// Interrupt
	output reg         irq
);
	localparam ST_IDLE  = 2'h0;
	localparam ST_WAIT  = 2'h1;
	localparam PS_IDLE  = 2'h0;
	localparam PS_DELAY = 2'h1;
	localparam PS_LOW   = 2'h2;

	reg  [2:0]  cfg_reg;
	reg  [7:0]  fast_reg;
	reg  [1:0]  st_reg;
	reg         gate_latch_reg;
	reg         rst_latch_reg;
	reg         ibf_reg;
	reg  [1:0]  kp_reg;
	reg  [15:0] kcnt_reg;
	reg  [1:0]  fp_reg;
	reg  [15:0] fcnt_reg;
	reg  [2:0]  ist_reg;
	reg  [2:0]  ien_reg;
	reg         aw_reg;
	reg         ar_reg;
	reg  [7:0]  aaddr_reg;
	reg         fast_pulse_req;
	reg         fast_armed_reg;
	reg  [2:0]  ev;
	wire        k_low;
	wire        f_low;
	wire        gate_sel;
	wire        rst_sel;
	wire        gate_hw;
	wire        rst_hw;
	wire        bus_wr;
	wire        cmd_wr;
	wire        dat_wr;
	wire        clr_wr;

	assign cmd_wr = host_wr & port_select_addr;
	assign dat_wr = host_wr & ~port_select_addr;
	assign gate_hw = cfg_reg[`CFG_GATE_HW_BIT];
	assign rst_hw  = cfg_reg[`CFG_RESET_HW_BIT];
	assign bus_wr = aw_reg;
	assign clr_wr = bus_wr && aaddr_reg == `IRQ_CLR_OFFSET;

	// AHB address phase capture, zero wait states
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aw_reg    <= 1'b0;
			ar_reg    <= 1'b0;
			aaddr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				aw_reg    <= hsel & htrans[1] & hwrite;
				ar_reg    <= hsel & htrans[1] & ~hwrite;
				aaddr_reg <= haddr[7:0];
			end
		end
	end

	// Read data, registered one cycle after address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				`CFG_OFFSET:      hrdata <= {29'h0, cfg_reg};
				`FAST_OFFSET:     hrdata <= {24'h0, fast_reg};
				`STAT_OFFSET:     hrdata <= {28'h0, ibf_reg, rst_latch_reg,
					gate_latch_reg, st_reg == ST_WAIT};
				`IRQ_STAT_OFFSET: hrdata <= {29'h0, ist_reg};
				`IRQ_EN_OFFSET:   hrdata <= {29'h0, ien_reg};
				default:          hrdata <= 32'h00000000;
			endcase
		end
	end

	// Config and fast port registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg  <= `CFG_RESET_VAL;
			fast_reg <= `FAST_RESET_VAL;
			ien_reg  <= 3'h0;
			fast_pulse_req <= 1'b0;
			fast_armed_reg <= 1'b1;
		end else begin
			fast_pulse_req <= 1'b0;
			if (bus_wr && aaddr_reg == `CFG_OFFSET)
				cfg_reg <= hwdata[2:0]; // [RULE_01]
			if (bus_wr && aaddr_reg == `IRQ_EN_OFFSET)
				ien_reg <= hwdata[2:0];
			if (bus_wr && aaddr_reg == `FAST_OFFSET) begin
				fast_reg <= hwdata[7:0];
				if (!hwdata[`FAST_RST_BIT])
					fast_armed_reg <= 1'b1; // [RULE_16]
				else if (fast_armed_reg && cfg_reg[`CFG_FAST_EN_BIT]) begin
					fast_pulse_req <= 1'b1; // [RULE_15]
					fast_armed_reg <= 1'b0; // [RULE_16]
				end
			end
		end
	end

	// Command/data sequencer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg          <= ST_IDLE;
			gate_latch_reg  <= 1'b0;
			rst_latch_reg   <= 1'b1;
			ibf_reg         <= 1'b0;
			input_full_flag <= 1'b0;
			output_full_irq <= 1'b0;
			fw_cmd_strobe   <= 1'b0;
			fw_cmd_data     <= 8'h00;
			fw_cmd_is_cmd   <= 1'b0;
			ev              <= 3'h0;
		end else begin
			fw_cmd_strobe   <= 1'b0;
			output_full_irq <= 1'b0; // [RULE_07]
			ev              <= 3'h0;
			if (cmd_wr && host_data == `CMD_PULSE_RESET && rst_hw) begin
				ev[1] <= 1'b0;
			end
			case (st_reg)
				ST_IDLE: begin
					if (cmd_wr && host_data == `CMD_WRITE_OUT && gate_hw)
						st_reg <= ST_WAIT;
					else if (cmd_wr && host_data == `CMD_PULSE_RESET && rst_hw)
						ibf_reg <= 1'b0; // [RULE_11]
					else if (cmd_wr && gate_hw && host_data == `CMD_NULL)
						ibf_reg <= ibf_reg; // [RULE_09]
					else if (host_wr) begin
						fw_cmd_strobe <= 1'b1; // [RULE_17]
						fw_cmd_data   <= host_data;
						fw_cmd_is_cmd <= port_select_addr;
						ibf_reg       <= 1'b1;
					end
				end
				ST_WAIT: begin
					if (dat_wr) begin
						gate_latch_reg <= host_data[1]; // [RULE_05] [RULE_08]
						rst_latch_reg  <= host_data[0]; // [RULE_06]
						st_reg <= ST_IDLE;
						ev[0]  <= 1'b1;
					end else if (cmd_wr && host_data != `CMD_WRITE_OUT) begin
						ibf_reg <= 1'b1; // [RULE_10]
						st_reg  <= ST_IDLE;
						ev[2]   <= 1'b1;
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
			// Firmware side cannot clear the input-full flag; reset or a hardware-handled pulse-reset command clears it
			if (ev[0] == 1'b0 && fw_cmd_strobe == 1'b0 && !host_wr &&
					!ibf_reg)
				ibf_reg <= 1'b0;
			input_full_flag <= ibf_reg;
		end
	end

	// Keyboard-path reset pulse: delay then low
	// Counts are whole clock cycles, so both phases round up
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			kp_reg   <= PS_IDLE;
			kcnt_reg <= 16'h0000;
		end else begin
			case (kp_reg)
				PS_IDLE: if (st_reg == ST_IDLE && cmd_wr && rst_hw &&
						host_data == `CMD_PULSE_RESET) begin
					kp_reg   <= PS_DELAY; // [RULE_11]
					kcnt_reg <= DELAY_CYC[15:0];
				end
				PS_DELAY: if (kcnt_reg == 16'h0001) begin
					kp_reg   <= PS_LOW;
					kcnt_reg <= LOW_CYC[15:0];
				end else kcnt_reg <= kcnt_reg - 16'h0001;
				PS_LOW: if (kcnt_reg == 16'h0001) kp_reg <= PS_IDLE;
					else kcnt_reg <= kcnt_reg - 16'h0001;
				default: kp_reg <= PS_IDLE;
			endcase
		end
	end

	// Fast-port reset pulse: delay then low
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fp_reg   <= PS_IDLE;
			fcnt_reg <= 16'h0000;
		end else begin
			case (fp_reg)
				PS_IDLE: if (fast_pulse_req) begin
					fp_reg   <= PS_DELAY; // [RULE_15]
					fcnt_reg <= DELAY_CYC[15:0];
				end
				PS_DELAY: if (fcnt_reg == 16'h0001) begin
					fp_reg   <= PS_LOW;
					fcnt_reg <= LOW_CYC[15:0];
				end else fcnt_reg <= fcnt_reg - 16'h0001;
				PS_LOW: if (fcnt_reg == 16'h0001) fp_reg <= PS_IDLE;
					else fcnt_reg <= fcnt_reg - 16'h0001;
				default: fp_reg <= PS_IDLE;
			endcase
		end
	end

	assign k_low = (kp_reg == PS_LOW);
	assign f_low = (fp_reg == PS_LOW) & cfg_reg[`CFG_FAST_EN_BIT];
	// One source each, then fast port merge
	assign gate_sel = (gate_hw ? gate_latch_reg : fw_gate) | // [RULE_02]
		(cfg_reg[`CFG_FAST_EN_BIT] & fast_reg[`FAST_A20_BIT]); // [RULE_04]
	assign rst_sel = (rst_hw ? (rst_latch_reg & ~k_low) : fw_reset_n) & // [RULE_03]
		~f_low; // [RULE_04]

	// Pin drivers with polarity; undriven until enabled after power-on
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr20_gate_out     <= 1'b0;
			addr20_gate_oe      <= 1'b0; // [RULE_14]
			cpu_reset_pulse_out <= 1'b1;
			cpu_reset_pulse_oe  <= 1'b0; // [RULE_14]
		end else begin
			addr20_gate_out     <= gate_sel ^ fast_reg[`FAST_GATE_POL_BIT]; // [RULE_12]
			cpu_reset_pulse_out <= rst_sel ^ fast_reg[`FAST_RST_POL_BIT]; // [RULE_13]
			addr20_gate_oe      <= fast_reg[`FAST_OE_BIT];
			cpu_reset_pulse_oe  <= fast_reg[`FAST_OE_BIT];
		end
	end

	// Sticky events: 0 gate update, 1 keyboard-path reset pulse done, 2 bad sequence
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ist_reg <= 3'h0;
			irq     <= 1'b0;
		end else begin
			ist_reg <= (ist_reg & ~(clr_wr ? hwdata[2:0] : 3'h0)) |
				{ev[2], (kp_reg == PS_LOW && kcnt_reg == 16'h0001), ev[0]};
			irq <= |(ist_reg & ien_reg);
		end
	end
endmodule // kbd_speedup

// file: kbd_speedup_checker.sv
`timescale 1ns/1ps
module kbd_speedup_checker (
	// Clock, reset and bus answer
	input wire       hclk,
	input wire       hresetn,
	input wire       hreadyout,
	input wire       hresp,
	// Host snoop and firmware side
	input wire       host_wr,
	input wire       port_select_addr,
	input wire [7:0] host_data,
	input wire [7:0] fw_cmd_data,
	input wire       input_full_flag,
	input wire       output_full_irq,
	input wire       fw_cmd_strobe,
	// Pins
	input wire       addr20_gate_oe,
	input wire       cpu_reset_pulse_oe,
	input wire       cpu_reset_pulse_out
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire fe_cmd = host_wr && port_select_addr && host_data == 8'hFE;
	property p_bus; hreadyout && !hresp; endproperty
	a_bus: assert property (p_bus) else $error("bus stalled");
	property p_oe; addr20_gate_oe == cpu_reset_pulse_oe; endproperty
	a_oe: assert property (p_oe) else $error("pin enables differ");
	property p_no_obf; !output_full_irq; endproperty
	a_no_obf: assert property (p_no_obf) else $error("obf raised");
	// Flag is two registers behind the host write that raised it
	property p_ibf_cause;
		$rose(input_full_flag) |-> $past(host_wr, 2);
	endproperty
	a_ibf_cause: assert property (p_ibf_cause) else $error("ibf no cause");
	property p_ibf_hold; input_full_flag |=> input_full_flag; endproperty
	a_ibf_hold: assert property (p_ibf_hold) else $error("ibf dropped");
	property p_fw;
		fw_cmd_strobe |-> $past(host_wr) && fw_cmd_data == $past(host_data);
	endproperty
	a_fw: assert property (p_fw) else $error("bad forward");
	// Keyboard reset may not start in the 3 cycles after the pulse-reset command
	property p_rst_wait;
		fe_cmd && cpu_reset_pulse_out |=> cpu_reset_pulse_out [*3];
	endproperty
	a_rst_wait: assert property (p_rst_wait) else $error("reset early");
	property p_rst_low;
		$fell(cpu_reset_pulse_out) |-> !cpu_reset_pulse_out [*2];
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("reset short");
	c_ibf: cover property ($rose(input_full_flag));
	c_rst: cover property ($fell(cpu_reset_pulse_out));
	c_fw: cover property (fw_cmd_strobe);
endmodule // kbd_speedup_checker
bind kbd_speedup kbd_speedup_checker u_chk (
	.hclk                (hclk),
	.hresetn             (hresetn),
	.hreadyout           (hreadyout),
	.hresp               (hresp),
	.host_wr             (host_wr),
	.port_select_addr    (port_select_addr),
	.host_data           (host_data),
	.fw_cmd_data         (fw_cmd_data),
	.input_full_flag     (input_full_flag),
	.output_full_irq     (output_full_irq),
	.fw_cmd_strobe       (fw_cmd_strobe),
	.addr20_gate_oe      (addr20_gate_oe),
	.cpu_reset_pulse_oe  (cpu_reset_pulse_oe),
	.cpu_reset_pulse_out (cpu_reset_pulse_out)
);

// file: kbd_host_model.sv
`timescale 1ns/1ps
module kbd_host_model (
	// Clock
	input  wire       hclk,
	// Keyboard port writes
	output reg        host_wr,
	output reg        port_select_addr,
	output reg  [7:0] host_data
);
	initial begin
		host_wr = 1'b0;
		port_select_addr = 1'b1;
		host_data = 8'h00;
	end
	// One byte per call, command port when cmd is set
	task send(input logic cmd, input logic [7:0] d);
		@(posedge hclk);
		host_wr <= 1'b1;
		port_select_addr <= cmd;
		host_data <= d;
		@(posedge hclk);
		host_wr <= 1'b0;
		host_data <= ~d; // Released bus must not look valid
	endtask
endmodule // kbd_host_model

// file: tb_keyboard_a20_reset_speedup.sv
`timescale 1ns/1ps
module tb_keyboard_a20_reset_speedup;
	localparam DLY = 4;
	localparam LOW = 2;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'b010;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        fw_gate = 1'b0;
	logic        fw_reset_n = 1'b1;
	wire         hready, hreadyout, hresp, host_wr, port_select_addr;
	wire  [31:0] hrdata;
	wire  [7:0]  host_data, fw_cmd_data;
	wire         input_full_flag, output_full_irq, fw_cmd_strobe;
	wire         fw_cmd_is_cmd, addr20_gate_out, addr20_gate_oe;
	wire         cpu_reset_pulse_out, cpu_reset_pulse_oe, irq;
	logic [31:0] rd, b;
	logic [7:0]  cfg, fast;
	logic        gl, rl;
	int          num_errors = 0, comparisons = 0, cyc = 0, hi, lows;
	int          seed = 32'hFC032370;
	assign hready = hreadyout;
	kbd_speedup #(.DELAY_CYC(DLY), .LOW_CYC(LOW)) DUT (
		.hclk                (hclk),
		.hresetn             (hresetn),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hwdata              (hwdata),
		.hready              (hready),
		.hrdata              (hrdata),
		.hreadyout           (hreadyout),
		.hresp               (hresp),
		.host_wr             (host_wr),
		.port_select_addr    (port_select_addr),
		.host_data           (host_data),
		.fw_gate             (fw_gate),
		.fw_reset_n          (fw_reset_n),
		.input_full_flag     (input_full_flag),
		.output_full_irq     (output_full_irq),
		.fw_cmd_strobe       (fw_cmd_strobe),
		.fw_cmd_data         (fw_cmd_data),
		.fw_cmd_is_cmd       (fw_cmd_is_cmd),
		.addr20_gate_out     (addr20_gate_out),
		.addr20_gate_oe      (addr20_gate_oe),
		.cpu_reset_pulse_out (cpu_reset_pulse_out),
		.cpu_reset_pulse_oe  (cpu_reset_pulse_oe),
		.irq                 (irq)
	);
	kbd_host_model host (.hclk(hclk), .host_wr(host_wr),
		.port_select_addr(port_select_addr), .host_data(host_data));
	always #20 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	function automatic logic exp_gate();
		return ((cfg[1] ? gl : fw_gate) | (cfg[2] & fast[1])) ^ fast[4];
	endfunction
	task chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
		if (a == 8'hF0) cfg = d[7:0];
		if (a == 8'hF4) fast = d[7:0];
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	task do_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		cfg = 8'h00;
		fast = 8'h00;
		rdc("cfg rst", 8'hF0, 32'h0);
		rdc("fast rst", 8'hF4, 32'h0);
		chk("oe rst", {addr20_gate_oe, cpu_reset_pulse_oe}, 0);
		chk("ibf rst", input_full_flag, 0);
	endtask
	task settle;
		repeat (3) @(negedge hclk);
	endtask
	// Measures high time before the reset pin drops and its low time
	task watch;
		hi = 0;
		lows = 0;
		repeat (20) begin
			@(negedge hclk);
			if (cpu_reset_pulse_out === 1'b0) lows++;
			else if (lows == 0) hi++;
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		do_reset;
		wr(8'hC0, 32'hFFFFFFFF);
		rdc("unmapped", 8'hC0, 32'h0);
		wr(8'hF0, 32'h3);
		rdc("cfg", 8'hF0, 32'h3);
		wr(8'hF4, 32'h40);
		settle;
		chk("oe on", {addr20_gate_oe, cpu_reset_pulse_oe}, 3);
		for (int i = 0; i < 4; i++) begin
			b = $random(seed);
			b[1] = ~i[0];
			b[0] = i[1];
			host.send(1'b1, 8'hD1);
			if (i == 2) host.send(1'b1, 8'hD1);
			host.send(1'b0, b[7:0]);
			host.send(1'b1, 8'hFF);
			gl = b[1];
			rl = b[0];
			settle;
			chk("gate", addr20_gate_out, exp_gate());
			rdc("status", 8'hF8, {28'h0, 1'b0, rl, gl, 1'b0});
			chk("ibf", input_full_flag, 0);
		end
		$display("gate sequences done");
		rdc("irq stat", 8'hFC, 32'h1);
		chk("irq masked", irq, 0);
		wr(8'hEC, 32'h1);
		settle;
		chk("irq on", irq, 1);
		wr(8'hE8, 32'h1);
		settle;
		chk("irq clr", irq, 0);
		wr(8'hF4, 32'h50);
		settle;
		chk("gate pol", addr20_gate_out, exp_gate());
		wr(8'hF4, 32'h60);
		settle;
		chk("rst pol", cpu_reset_pulse_out, 0);
		wr(8'hF4, 32'h42);
		settle;
		chk("force off", addr20_gate_out, exp_gate());
		wr(8'hF0, 32'h7);
		settle;
		chk("force on", addr20_gate_out, exp_gate());
		wr(8'hF4, 32'h40);
		host.send(1'b1, 8'hFE);
		watch;
		chk("rst wait", hi >= DLY - 1 && hi <= DLY + 3, 1);
		chk("rst low", lows >= LOW, 1);
		chk("rst ibf", input_full_flag, 0);
		wr(8'hF4, 32'h41);
		watch;
		chk("fast pulse", lows >= LOW, 1);
		wr(8'hF4, 32'h41);
		watch;
		chk("no repeat", lows, 0);
		wr(8'hF4, 32'h40);
		wr(8'hF4, 32'h41);
		watch;
		chk("rearm", lows >= LOW, 1);
		$display("reset pulses done");
		host.send(1'b1, 8'hD1);
		host.send(1'b1, 8'hAB);
		host.send(1'b1, 8'hFF);
		settle;
		chk("bad ibf", input_full_flag, 1);
		chk("bad gate", addr20_gate_out, exp_gate());
		do_reset;
		wr(8'hF4, 32'h40);
		b = $random(seed);
		@(posedge hclk);
		fw_gate <= b[0];
		host.send(1'b1, 8'hD1);
		host.send(1'b0, {6'h0, ~b[0], 1'b1});
		settle;
		chk("fw gate", addr20_gate_out, exp_gate());
		chk("fw ibf", input_full_flag, 1);
		chk("fw data", fw_cmd_data, {6'h0, ~b[0], 1'b1});
		chk("fw kind", fw_cmd_is_cmd, 0);
		@(posedge hclk);
		fw_reset_n <= 1'b0;
		settle;
		chk("fw rst", cpu_reset_pulse_out, 0);
		@(posedge hclk);
		fw_reset_n <= 1'b1;
		host.send(1'b1, 8'hFE);
		watch;
		chk("fw no pulse", lows, 0);
		chk("fw fe data", fw_cmd_data, 8'hFE);
		chk("fw fe kind", fw_cmd_is_cmd, 1);
		$display("firmware mode done");
		tally_and_finish;
	end
endmodule // tb_keyboard_a20_reset_speedup
